//--- testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic mclk = 0, rst_n = 0, want = 0, pin, sel = 0, clr = 0, en = 0;
  logic [3:0] md = 4'h0;
  logic [15:0] ta = 16'h0000, tb = 16'h0000, exp_v = 16'h0000;
  tcu_pkg::tcu_cap_t pair;
  logic [7:0] hi, lo;
  logic flag, irq, stb;
  int seed = 54, fail_count = 0, checks = 0, n;
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    ta <= ta + 16'h0001;
    tb <= 16'($random(seed));
  end
  tcu_pin_src u_tcu_pin_src (.mclk(mclk), .want(want), .pin(pin));
  tcu_capture u_tcu_capture (.mclk(mclk), .rst_n(rst_n),
    .capture_input_pin(pin), .capture_mode_field(md), .timer_b_select(sel),
    .timer_a_count(ta), .timer_b_count(tb), .flag_clear(clr),
    .capture_irq_enable(en), .capture_value_pair(pair),
    .capture_value_high(hi), .capture_value_low(lo),
    .capture_irq_flag(flag), .capture_irq(irq), .capture_strobe(stb));
  // ****************
  // Checking tasks
  // ****************
  task chk(input string what, input logic [15:0] seen, input logic [15:0] e);
    checks++;
    if (seen !== e) begin
      fail_count++;
      $display("wrong value %s exp %h seen %h", what, e, seen);
    end
  endtask
  task tally_and_finish;
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task step(input logic v, input logic cap);
    @(posedge mclk) want <= v;
    repeat (3) @(posedge mclk);
    #1 if (cap) exp_v = sel ? tb : ta;
    chk("strobe", 16'(stb), 16'(cap));
    @(posedge mclk);
    #1 chk("pair", pair, exp_v);
    chk("halves", {hi, lo}, exp_v);
    if (cap) chk("flag", 16'(flag), 16'h0001);
  endtask
  // Rising edges that make one capture in each mode; in mode 4 the capture comes on the fall after the one rise.
  function automatic int rises_per_capture(input int m);
    if (m == 6) return 4;
    if (m == 7) return 16;
    return 1;
  endfunction
  // A run of rising edges in which only the last one may capture.
  task rises(input int cnt, input logic cap);
    for (int j = 1; j <= cnt; j++) begin
      step(1, cap && j == cnt);
      step(0, 0);
    end
  endtask
  // Clearing first keeps the mode-change flag apart from capture flags.
  task set_mode(input logic [3:0] m);
    @(posedge mclk) clr <= 1;
    @(posedge mclk);
    clr <= 0;
    md <= m;
    sel <= 1'($random(seed));
    en <= 1'($random(seed));
    repeat (2) @(posedge mclk);
    #1 chk("mode flag", 16'(flag), 16'(m[2]));
    chk("irq", 16'(irq), 16'(m[2] & en));
    @(posedge mclk) clr <= 1;
    @(posedge mclk) clr <= 0;
    #1 chk("cleared", 16'(flag), 16'h0000);
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1;
    for (int r = 0; r < 3; r++) begin
      for (int m = 4; m < 8; m++) begin
        set_mode(4'h0);
        step(1, 0);
        step(0, 0);
        set_mode(4'(m));
        n = rises_per_capture(m);
        for (int j = 1; j <= n; j++) begin
          step(1, j == n && m != 4);
          step(0, m == 4);
        end
        // Leftover counts must be wiped by the following off mode.
        if (m > 5) repeat (2) begin
          step(1, 0);
          step(0, 0);
        end
      end
    end
    // Direct prescaler switches keep the partial count both ways.
    set_mode(4'h0);
    set_mode(4'h6);
    rises(2, 0);
    set_mode(4'h7);
    rises(14, 1);
    rises(5, 0);
    set_mode(4'h6);
    rises(1, 1);
    // A reset in mid-run must also wipe a partial count.
    rises(2, 0);
    @(posedge mclk) rst_n <= 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1;
    exp_v = 16'h0000;
    rises(4, 1);
    tally_and_finish;
  end
  initial begin
    #200000;
    fail_count++;
    tally_and_finish;
  end
endmodule

//--- testbench/tcu_checker.sv
`timescale 1ns/10ps
`include "tcu_defs.svh"
module tcu_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic capture_input_pin,
  input wire logic [`TCU_MODE_W-1:0] capture_mode_field,
  input wire logic timer_b_select,
  input wire logic [`TCU_TMR_W-1:0] timer_a_count,
  input wire logic [`TCU_TMR_W-1:0] timer_b_count,
  input wire logic flag_clear,
  input wire logic capture_irq_enable,
  input wire tcu_pkg::tcu_cap_t capture_value_pair,
  input wire logic [7:0] capture_value_high,
  input wire logic [7:0] capture_value_low,
  input wire logic capture_irq_flag,
  input wire logic capture_irq,
  input wire logic capture_strobe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire logic [15:0] src = timer_b_select ? timer_b_count : timer_a_count;
  wire logic [3:0] md = capture_mode_field;
  wire logic cap_md = md[2] & ~md[3];
  // The pin edge is seen two edges late, after the synchroniser.
  sequence s_rise;
    $rose(capture_input_pin) ##0 (md == `TCU_MODE_RISE)[*3];
  endsequence
  sequence s_fall;
    $fell(capture_input_pin) ##0 (md == `TCU_MODE_FALL)[*3];
  endsequence
  a_value_load: assert property (
    capture_strobe |=> capture_value_pair == $past(src)) else $error("load");
  a_pair_halves: assert property (
    capture_value_pair == {capture_value_high, capture_value_low})
    else $error("halves");
  a_flag_on_cap: assert property (
    capture_strobe |=> capture_irq_flag) else $error("flag set");
  a_flag_sticky: assert property (
    $fell(capture_irq_flag) |-> $past(flag_clear)) else $error("flag drop");
  a_idle_mode: assert property (
    !cap_md |-> !capture_strobe) else $error("idle capture");
  a_rise_cap: assert property (
    s_rise |-> capture_strobe) else $error("rise");
  a_fall_cap: assert property (
    s_fall |-> capture_strobe) else $error("fall");
  a_mode_flag: assert property (
    $changed(md) && cap_md |=> capture_irq_flag) else $error("mode flag");
endmodule

bind tcu_capture tcu_checker u_tcu_checker (
  .mclk(mclk),
  .rst_n(rst_n),
  .capture_input_pin(capture_input_pin),
  .capture_mode_field(capture_mode_field),
  .timer_b_select(timer_b_select),
  .timer_a_count(timer_a_count),
  .timer_b_count(timer_b_count),
  .flag_clear(flag_clear),
  .capture_irq_enable(capture_irq_enable),
  .capture_value_pair(capture_value_pair),
  .capture_value_high(capture_value_high),
  .capture_value_low(capture_value_low),
  .capture_irq_flag(capture_irq_flag),
  .capture_irq(capture_irq),
  .capture_strobe(capture_strobe)
);

//--- testbench/tcu_pin_src.sv
`timescale 1ns/10ps
module tcu_pin_src (
  input wire logic mclk,
  input wire logic want,
  output logic pin
);
  // Only the source moves the pin, so every event is a real one.
  always_ff @(posedge mclk) begin
    pin <= want;
  end
endmodule

//--- verilog/tcu_capture.sv
`timescale 1ns/10ps
`include "tcu_defs.svh"


module tcu_capture (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic capture_input_pin,
  input wire logic [`TCU_MODE_W-1:0] capture_mode_field,
  input wire logic timer_b_select,
  input wire logic [`TCU_TMR_W-1:0] timer_a_count,
  input wire logic [`TCU_TMR_W-1:0] timer_b_count,
  input wire logic flag_clear,
  input wire logic capture_irq_enable,
  output tcu_pkg::tcu_cap_t capture_value_pair,
  output logic [7:0] capture_value_high,
  output logic [7:0] capture_value_low,
  output logic capture_irq_flag,
  output logic capture_irq,
  output logic capture_strobe
);

  // ****************************************************************
  // Edge detection
  // ****************************************************************

  logic pin_rise;
  logic pin_fall;

  // The pin level is watched whatever drives it, so a port write on an
  // output-configured pin can cause a capture just like an outside edge.
  tcu_edge_sync u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin_in(capture_input_pin),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // ****************************************************************
  // Mode decode
  // ****************************************************************

  tcu_pkg::tcu_ev_kind_t kind;
  logic [`TCU_PRE_W-1:0] pre_last;

  always_comb begin
    kind = tcu_pkg::TCU_EV_NONE;
    pre_last = `TCU_PRE_LAST4;
    case (capture_mode_field)
      `TCU_MODE_FALL: kind = tcu_pkg::TCU_EV_FALL;
      `TCU_MODE_RISE: kind = tcu_pkg::TCU_EV_RISE;
      `TCU_MODE_RISE4: begin
        kind = tcu_pkg::TCU_EV_PRESCALED;
        pre_last = `TCU_PRE_LAST4;
      end
      `TCU_MODE_RISE16: begin
        kind = tcu_pkg::TCU_EV_PRESCALED;
        pre_last = `TCU_PRE_LAST16;
      end
      default: kind = tcu_pkg::TCU_EV_NONE;
    endcase
  end

  // ****************************************************************
  // Edge prescaler
  // ****************************************************************

  logic [`TCU_PRE_W-1:0] pre_r;
  logic pre_hit;

  // A count left over from a x16 setting can reach past the x4 terminal;
  // the compare uses >= so the counter still wraps rather than running on.
  assign pre_hit = pin_rise && (pre_r >= pre_last);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= '0;
    end else if (kind != tcu_pkg::TCU_EV_PRESCALED &&
                 kind != tcu_pkg::TCU_EV_RISE &&
                 kind != tcu_pkg::TCU_EV_FALL) begin
      pre_r <= '0;
    end else if (kind == tcu_pkg::TCU_EV_PRESCALED && pin_rise) begin
      // Switching between prescaled settings keeps the count.
      pre_r <= pre_hit ? '0 : pre_r + 1'b1;
    end
  end

  // ****************************************************************
  // Capture event and mode-change artefact
  // ****************************************************************

  logic [`TCU_MODE_W-1:0] mode_prev_r;
  logic mode_changed;
  logic event_hit;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_prev_r <= `TCU_MODE_OFF;
    end else begin
      mode_prev_r <= capture_mode_field;
    end
  end

  // Any change into a capture mode raises the flag once, as the real
  // part may; software is expected to mask and then clear it.
  assign mode_changed = (capture_mode_field != mode_prev_r) &&
                        (kind != tcu_pkg::TCU_EV_NONE);

  always_comb begin
    case (kind)
      tcu_pkg::TCU_EV_FALL: event_hit = pin_fall;
      tcu_pkg::TCU_EV_RISE: event_hit = pin_rise;
      tcu_pkg::TCU_EV_PRESCALED: event_hit = pre_hit;
      default: event_hit = 1'b0;
    endcase
  end

  assign capture_strobe = event_hit;

  // ****************************************************************
  // Holding registers
  // ****************************************************************

  logic [`TCU_TMR_W-1:0] src_count;
  logic [`TCU_TMR_W-1:0] cap_r;

  // The timer is assumed to be synchronous to mclk; a count that ripples
  // asynchronously would be sampled mid-change here.
  assign src_count = timer_b_select ? timer_b_count
                                    : timer_a_count;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cap_r <= `TCU_CAP_RST;
    end else if (event_hit) begin
      cap_r <= src_count;
    end
  end

  assign capture_value_pair = cap_r;
  assign capture_value_high = cap_r[15:8];
  assign capture_value_low = cap_r[7:0];

  // ****************************************************************
  // Interrupt flag
  // ****************************************************************

  logic flag_r;

  // A set in the same cycle as a software clear wins.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (event_hit || mode_changed) begin
      flag_r <= 1'b1;
    end else if (flag_clear) begin
      flag_r <= 1'b0;
    end
  end

  assign capture_irq_flag = flag_r;
  assign capture_irq = flag_r & capture_irq_enable;

endmodule

//--- verilog/tcu_defs.svh
`ifndef TCU_DEFS_SVH
`define TCU_DEFS_SVH

// Capture mode field encodings (four bits).
`define TCU_MODE_W 4
`define TCU_MODE_OFF 4'h0
`define TCU_MODE_FALL 4'h4
`define TCU_MODE_RISE 4'h5
`define TCU_MODE_RISE4 4'h6
`define TCU_MODE_RISE16 4'h7

// Edge prescaler: counter width and terminal counts.
`define TCU_PRE_W 4
`define TCU_PRE_LAST4 4'h3
`define TCU_PRE_LAST16 4'hf

// Timer width and reset value of the holding registers.
`define TCU_TMR_W 16
`define TCU_CAP_RST 16'h0000

`endif

//--- verilog/tcu_edge_sync.sv
`timescale 1ns/10ps
`include "tcu_defs.svh"

module tcu_edge_sync (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pin_in,
  output logic rise,
  output logic fall
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;

endmodule

//--- verilog/tcu_pkg.sv
`include "tcu_defs.svh"

package tcu_pkg;

  typedef enum logic [1:0] {
    TCU_EV_NONE,
    TCU_EV_FALL,
    TCU_EV_RISE,
    TCU_EV_PRESCALED
  } tcu_ev_kind_t;

  // Captured pair as presented to software.
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } tcu_cap_t;

endpackage
